// >>> verilog/lipc_ctrl.sv
// serial port and isa pass-through control registers with interrupt gating
//
// Behaviour
// - mode one bit 4 enables port 1 automatic direction; use only with RS-485.
// - auto direction on: transmit enabled while bytes remain, tri-stated otherwise.
// - auto direction off with RS-485: RTS 0 enables transmit, RTS 1 tri-states it; RS-232 always enables.
// - mode one bits 1,0 enable ports 2,1; zero disables Tx/RTS, forwards to ISA.
// - a disabled port's io range is not decoded to the port; accesses to it are forwarded to isa.
// - reserved bits ignore writes and read zero.
// - mode two bit 0: zero multiplies divisor by 16, one uses it as is.
// - each set gate passes its isa line to serial irq unlatched; clear blocks.
// - gate low bits 7..0 gate lines 11,10,9,7,6,5,4,3.
// - gate high bits 2,1,0 gate lines 15,14,12; bit 3 reserved.
// - isa interrupt inputs are active high.
// - forwarding ignores the global serial irq enable.
// - gate high bit 7 sets on forwarded access, read-clears, ignores writes.
// - gate high bit 4: zero allows 8 and 16 bit, one 16 bit only.
// - mode registers take defaults on platform reset.
`timescale 1ns/1ps
`default_nettype none
module lipc_ctrl #(
   parameter int DIV_WIDTH = 16
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic [1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic port1_hit,
   input wire logic port2_hit,
   input wire logic isa_cycle,
   output logic port1_decode,
   output logic port2_decode,
   output logic isa_forward,
   output logic isa_wide_only_sel,
   input wire logic [DIV_WIDTH-1:0] divisor,
   output logic [DIV_WIDTH+3:0] baud_divisor,
   input wire logic [1:0] port_xcvr_select,
   input wire logic [1:0] port_tx_busy,
   input wire logic [1:0] port_rts_bit,
   input wire logic [1:0] port_tx_in,
   input wire logic [1:0] port_rts_in,
   output logic [1:0] port_tx_out,
   output logic [1:0] port_tx_oe,
   output logic [1:0] port_rts_out,
   output logic [1:0] port_rts_oe,
   input wire logic [10:0] isa_irq_in,
   output logic [10:0] serirq_req
);
   typedef struct packed {
      logic [7:0] mode_one;
      logic [7:0] mode_two;
      logic [7:0] gate_low;
      logic [7:0] gate_high;
      logic [7:0] rdata;
      logic p1_dec;
      logic p2_dec;
      logic fwd;
      logic [DIV_WIDTH+3:0] baud;
      logic [10:0] irq;
   } lipc_state_type;

   lipc_state_type st_reg;
   lipc_state_type st_next;
   logic [10:0] gates;
   logic [1:0] port_en;
   logic [1:0] auto_en;
   logic fwd_now;

   function automatic logic [7:0] masked_write(input logic [7:0] old, input logic [7:0] wd, input logic [7:0] msk);
      masked_write = (old & ~msk) | (wd & msk);
   endfunction

   // line order: 3,4,5,6,7,9,10,11,12,14,15
   assign gates = {st_reg.gate_high[2:0], st_reg.gate_low};
   assign port_en = {st_reg.mode_one[lipc_pkg::MODE1_P2_OEN], st_reg.mode_one[lipc_pkg::MODE1_P1_OEN]};
   assign auto_en = {st_reg.mode_one[lipc_pkg::MODE1_P2_AUTO], st_reg.mode_one[lipc_pkg::MODE1_P1_AUTO]};
   // a disabled port's range falls through to isa
   assign fwd_now = isa_cycle || (port1_hit && !port_en[0]) || (port2_hit && !port_en[1]);

   //==========================================================
   // register file
   always_comb begin
      st_next = st_reg;
      st_next.p1_dec = port1_hit && port_en[0];
      st_next.p2_dec = port2_hit && port_en[1];
      st_next.fwd = fwd_now;
      st_next.irq = isa_irq_in & gates;
      if (st_reg.mode_two[lipc_pkg::MODE2_FAST]) begin
         st_next.baud = {4'h0, divisor};
      end else begin
         st_next.baud = {divisor, 4'h0};
      end
      if (reg_wr) begin
         unique case (reg_addr)
            lipc_pkg::ADDR_MODE_ONE: st_next.mode_one = masked_write(st_reg.mode_one, reg_wdata, lipc_pkg::MODE1_WMASK);
            lipc_pkg::ADDR_MODE_TWO: st_next.mode_two = masked_write(st_reg.mode_two, reg_wdata, lipc_pkg::MODE2_WMASK);
            lipc_pkg::ADDR_GATE_LOW: st_next.gate_low = masked_write(st_reg.gate_low, reg_wdata, lipc_pkg::GATE_LOW_WMASK);
            lipc_pkg::ADDR_GATE_HIGH: st_next.gate_high = masked_write(st_reg.gate_high, reg_wdata,
                                                                       lipc_pkg::GATE_HIGH_WMASK);
         endcase
      end
      if (reg_rd) begin
         unique case (reg_addr)
            lipc_pkg::ADDR_MODE_ONE: st_next.rdata = st_reg.mode_one;
            lipc_pkg::ADDR_MODE_TWO: st_next.rdata = st_reg.mode_two;
            lipc_pkg::ADDR_GATE_LOW: st_next.rdata = st_reg.gate_low;
            lipc_pkg::ADDR_GATE_HIGH: begin
               st_next.rdata = st_reg.gate_high;
               st_next.gate_high[lipc_pkg::GATE_HIGH_FLAG] = 1'b0;
            end
         endcase
      end
      if (fwd_now) begin
         st_next.gate_high[lipc_pkg::GATE_HIGH_FLAG] = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         st_reg <= '0;
         st_reg.mode_one <= lipc_pkg::MODE1_RESET;
         st_reg.mode_two <= lipc_pkg::MODE2_RESET;
         st_reg.gate_low <= lipc_pkg::GATE_LOW_RESET;
         st_reg.gate_high <= lipc_pkg::GATE_HIGH_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   assign reg_rdata = st_reg.rdata;
   assign port1_decode = st_reg.p1_dec;
   assign port2_decode = st_reg.p2_dec;
   assign isa_forward = st_reg.fwd;
   assign isa_wide_only_sel = st_reg.gate_high[lipc_pkg::GATE_HIGH_WIDE];
   assign baud_divisor = st_reg.baud;
   assign serirq_req = st_reg.irq;

   //==========================================================
   // per-port direction control
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_port
         lipc_dir_ctrl u_dir (
            .clock(clock),
            .nrst(nrst),
            .port_en(port_en[gi]),
            .xcvr_485(port_xcvr_select[gi]),
            .auto_dir_en(auto_en[gi]),
            .tx_busy(port_tx_busy[gi]),
            .rts_bit(port_rts_bit[gi]),
            .tx_in(port_tx_in[gi]),
            .rts_in(port_rts_in[gi]),
            .tx_out(port_tx_out[gi]),
            .tx_oe(port_tx_oe[gi]),
            .rts_out(port_rts_out[gi]),
            .rts_oe(port_rts_oe[gi])
         );
      end
   endgenerate

   //==========================================================
   // checks
   chk_reserved_zero: assert property (@(posedge clock) disable iff (!nrst)
      (st_reg.mode_one[7:6] == 2'h0) && (st_reg.mode_one[3:2] == 2'h0) && (st_reg.mode_two[7:1] == 7'h00)
      && (st_reg.gate_high[6:5] == 2'h0) && (st_reg.gate_high[3] == 1'b0))
      else $error("reserved bit nonzero");
   chk_mode_write: assert property (@(posedge clock) disable iff (!nrst)
      reg_wr && reg_addr == lipc_pkg::ADDR_MODE_ONE |=> st_reg.mode_one == ($past(reg_wdata) & lipc_pkg::MODE1_WMASK))
      else $error("mode one write not masked");
   chk_irq_gating: assert property (@(posedge clock) disable iff (!nrst)
      1'b1 |=> serirq_req == ($past(isa_irq_in) & $past(gates)))
      else $error("irq gating mismatch");
   chk_flag_sets: assert property (@(posedge clock) disable iff (!nrst)
      fwd_now |=> st_reg.gate_high[lipc_pkg::GATE_HIGH_FLAG])
      else $error("forwarded access not flagged");
   chk_flag_clears: assert property (@(posedge clock) disable iff (!nrst)
      reg_rd && reg_addr == lipc_pkg::ADDR_GATE_HIGH && !fwd_now |=> !st_reg.gate_high[lipc_pkg::GATE_HIGH_FLAG])
      else $error("flag not cleared by read");
   chk_flag_no_write: assert property (@(posedge clock) disable iff (!nrst)
      reg_wr && reg_addr == lipc_pkg::ADDR_GATE_HIGH && !reg_rd && !fwd_now
      |=> st_reg.gate_high[lipc_pkg::GATE_HIGH_FLAG] == $past(st_reg.gate_high[lipc_pkg::GATE_HIGH_FLAG]))
      else $error("flag changed by write");
   chk_isa_forward: assert property (@(posedge clock) disable iff (!nrst)
      isa_cycle |=> isa_forward)
      else $error("isa cycle not forwarded");
   chk_read_before: assert property (@(posedge clock) disable iff (!nrst)
      reg_rd && reg_addr == lipc_pkg::ADDR_GATE_HIGH |=> reg_rdata == $past(st_reg.gate_high))
      else $error("read value not captured before clear");
   chk_no_decode: assert property (@(posedge clock) disable iff (!nrst)
      port1_hit && !port_en[0] |=> !port1_decode && isa_forward)
      else $error("disabled port decoded");
   chk_decode_enabled: assert property (@(posedge clock) disable iff (!nrst)
      port2_hit && port_en[1] |=> port2_decode)
      else $error("enabled port not decoded");
   chk_baud_legacy: assert property (@(posedge clock) disable iff (!nrst)
      !st_reg.mode_two[0] |=> baud_divisor == {$past(divisor), 4'h0})
      else $error("legacy divisor not scaled");
   chk_baud_fast: assert property (@(posedge clock) disable iff (!nrst)
      st_reg.mode_two[lipc_pkg::MODE2_FAST] |=> baud_divisor == {4'h0, $past(divisor)})
      else $error("fast divisor modified");
   chk_wide_write: assert property (@(posedge clock) disable iff (!nrst)
      reg_wr && reg_addr == lipc_pkg::ADDR_GATE_HIGH |=> isa_wide_only_sel == $past(reg_wdata[lipc_pkg::GATE_HIGH_WIDE]))
      else $error("wide only select not written");
   chk_reset_mode: assert property (@(posedge clock)
      !nrst |=> st_reg.mode_one == lipc_pkg::MODE1_RESET && st_reg.mode_two == lipc_pkg::MODE2_RESET)
      else $error("mode registers not reset");
   cov_flag_read: cover property (@(posedge clock) disable iff (!nrst)
      fwd_now ##1 reg_rd && reg_addr == lipc_pkg::ADDR_GATE_HIGH);
   cov_fast: cover property (@(posedge clock) disable iff (!nrst) st_reg.mode_two[0]);
   cov_irq: cover property (@(posedge clock) disable iff (!nrst) serirq_req != 11'h000);
   cov_disabled_hit: cover property (@(posedge clock) disable iff (!nrst) port1_hit && !port_en[0]);
endmodule
`default_nettype wire

// >>> inc/lipc_pkg.sv
// package of offsets, field positions and reset values for the legacy io pass-through control
package lipc_pkg;
   // register indices on the io register port
   localparam logic [1:0] ADDR_MODE_ONE = 2'h0;
   localparam logic [1:0] ADDR_MODE_TWO = 2'h1;
   localparam logic [1:0] ADDR_GATE_LOW = 2'h2;
   localparam logic [1:0] ADDR_GATE_HIGH = 2'h3;
   // serial_port_mode_one fields
   localparam int MODE1_P2_AUTO = 5;
   localparam int MODE1_P1_AUTO = 4;
   localparam int MODE1_P2_OEN = 1;
   localparam int MODE1_P1_OEN = 0;
   localparam logic [7:0] MODE1_WMASK = 8'h33;
   localparam logic [7:0] MODE1_RESET = 8'h03;
   // serial_port_mode_two fields
   localparam int MODE2_FAST = 0;
   localparam logic [7:0] MODE2_WMASK = 8'h01;
   localparam logic [7:0] MODE2_RESET = 8'h00;
   // isa_irq_gate_low: bits 7..0 gate lines 11,10,9,7,6,5,4,3
   localparam logic [7:0] GATE_LOW_WMASK = 8'hFF;
   localparam logic [7:0] GATE_LOW_RESET = 8'h00;
   // isa_irq_gate_high_and_mode fields
   localparam int GATE_HIGH_FLAG = 7;
   localparam int GATE_HIGH_WIDE = 4;
   localparam logic [7:0] GATE_HIGH_WMASK = 8'h17;
   localparam logic [7:0] GATE_HIGH_RESET = 8'h00;
   // baud divisor shift in legacy mode (multiply by 16)
   localparam int DIV_SHIFT = 4;
   localparam int ISA_LINES = 11;
endpackage

// >>> verilog/lipc_dir_ctrl.sv
// transmit direction and output gating for one serial port
`timescale 1ns/1ps
`default_nettype none
module lipc_dir_ctrl (
   input wire logic clock,
   input wire logic nrst,
   input wire logic port_en,
   input wire logic xcvr_485,
   input wire logic auto_dir_en,
   input wire logic tx_busy,
   input wire logic rts_bit,
   input wire logic tx_in,
   input wire logic rts_in,
   output logic tx_out,
   output logic tx_oe,
   output logic rts_out,
   output logic rts_oe
);
   typedef struct packed {
      logic tx_out;
      logic tx_oe;
      logic rts_out;
      logic rts_oe;
   } lipc_dir_state_type;

   lipc_dir_state_type st_reg;
   lipc_dir_state_type st_next;

   always_comb begin
      st_next.tx_out = tx_in;
      st_next.rts_out = rts_in;
      st_next.rts_oe = port_en;
      if (!port_en) begin
         st_next.tx_oe = 1'b0;
      end else if (xcvr_485 && auto_dir_en) begin
         st_next.tx_oe = tx_busy;
      end else if (xcvr_485) begin
         st_next.tx_oe = ~rts_bit;
      end else begin
         st_next.tx_oe = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign tx_out = st_reg.tx_out;
   assign tx_oe = st_reg.tx_oe;
   assign rts_out = st_reg.rts_out;
   assign rts_oe = st_reg.rts_oe;

   chk_auto_dir_follow: assert property (@(posedge clock) disable iff (!nrst)
      port_en && xcvr_485 && auto_dir_en |=> tx_oe == $past(tx_busy))
      else $error("auto direction enable does not follow busy");
   chk_manual_rts: assert property (@(posedge clock) disable iff (!nrst)
      port_en && xcvr_485 && !auto_dir_en |=> tx_oe == !$past(rts_bit))
      else $error("manual direction does not follow rts");
   chk_disabled_quiet: assert property (@(posedge clock) disable iff (!nrst)
      !port_en |=> !tx_oe && !rts_oe)
      else $error("disabled port drives outputs");
   cov_auto_send: cover property (@(posedge clock) disable iff (!nrst)
      port_en && xcvr_485 && auto_dir_en && tx_busy ##1 !tx_busy);
endmodule
`default_nettype wire

// >>> test/lipc_far_model.sv
// far side model: serial line transceivers and isa interrupt sources
`timescale 1ns/1ps
`default_nettype none
module lipc_far_model (
   input wire logic clock,
   input wire logic [1:0] port_tx_out,
   input wire logic [1:0] port_tx_oe,
   input wire logic [10:0] irq_level,
   output logic [10:0] isa_irq_in,
   output logic [1:0] line
);
   logic [1:0] last_reg = 2'h0;
   // isa cards drive their interrupt lines high-true
   assign isa_irq_in = irq_level;
   // a released line shows the inverse of the last driven level
   assign line = (port_tx_oe & port_tx_out) | (~port_tx_oe & ~last_reg);
   always @(posedge clock) begin
      for (int b = 0; b < 2; b++) begin
         if (port_tx_oe[b]) begin
            last_reg[b] <= port_tx_out[b];
         end
      end
   end
endmodule
`default_nettype wire

// >>> test/legacy_io_isa_passthrough_ctrl_tb.sv
// testbench for the legacy io pass-through control registers
`timescale 1ns/1ps
`default_nettype none
module legacy_io_isa_passthrough_ctrl_tb;
   logic clock, nrst, reg_wr, reg_rd, port1_hit, port2_hit, isa_cycle;
   logic port1_decode, port2_decode, isa_forward, isa_wide_only_sel;
   logic [1:0] reg_addr, port_xcvr_select, port_tx_busy, port_rts_bit, port_tx_in, port_rts_in;
   logic [1:0] port_tx_out, port_tx_oe, port_rts_out, port_rts_oe, line;
   logic [7:0] reg_wdata, reg_rdata;
   logic [15:0] divisor;
   logic [19:0] baud_divisor;
   logic [10:0] isa_irq_in, serirq_req, irq_level;
   logic [1:0] adr [4] = '{lipc_pkg::ADDR_MODE_ONE, lipc_pkg::ADDR_MODE_TWO, lipc_pkg::ADDR_GATE_LOW,
                           lipc_pkg::ADDR_GATE_HIGH};
   logic [7:0] rst_val [4] = '{8'h03, 8'h00, 8'h00, 8'h00};
   logic [7:0] wr_val [4] = '{8'h33, 8'h01, 8'hFF, 8'h17};
   int n_errors = 0;
   int n_compared = 0;

   lipc_ctrl #(.DIV_WIDTH(16)) u_dut (.clock(clock), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .port1_hit(port1_hit),
      .port2_hit(port2_hit), .isa_cycle(isa_cycle), .port1_decode(port1_decode),
      .port2_decode(port2_decode), .isa_forward(isa_forward), .isa_wide_only_sel(isa_wide_only_sel),
      .divisor(divisor), .baud_divisor(baud_divisor), .port_xcvr_select(port_xcvr_select),
      .port_tx_busy(port_tx_busy), .port_rts_bit(port_rts_bit), .port_tx_in(port_tx_in),
      .port_rts_in(port_rts_in), .port_tx_out(port_tx_out), .port_tx_oe(port_tx_oe),
      .port_rts_out(port_rts_out), .port_rts_oe(port_rts_oe), .isa_irq_in(isa_irq_in), .serirq_req(serirq_req));
   lipc_far_model u_far (.clock(clock), .port_tx_out(port_tx_out), .port_tx_oe(port_tx_oe),
      .irq_level(irq_level), .isa_irq_in(isa_irq_in), .line(line));

   // ==========================================
   // access tasks, all entered at a falling edge
   task automatic chk(string nm, logic [19:0] exp, logic [19:0] got);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(logic [1:0] a, logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clock);
      reg_wr = 1'b0;
      @(negedge clock);
   endtask
   task automatic rd(logic [1:0] a, logic [7:0] exp, string nm);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clock);
      reg_rd = 1'b0;
      isa_cycle = 1'b0;
      chk(nm, {12'h000, exp}, {12'h000, reg_rdata});
      @(negedge clock);
   endtask
   task automatic io(logic h1, logic h2, logic [1:0] exp_dec, logic exp_fwd);
      port1_hit = h1;
      port2_hit = h2;
      @(negedge clock);
      port1_hit = 1'b0;
      port2_hit = 1'b0;
      chk("decode", {18'h0, exp_dec}, {18'h0, port2_decode, port1_decode});
      chk("forward", {19'h0, exp_fwd}, {19'h0, isa_forward});
      @(negedge clock);
   endtask
   task automatic end_of_test;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // ==========================================
   // clock, watchdog and test sequence
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   initial begin
      #20000;
      n_errors++;
      end_of_test();
   end
   initial begin
      nrst = 1'b0;
      {reg_wr, reg_rd, port1_hit, port2_hit, isa_cycle} = 5'h00;
      reg_addr = 2'h0;
      reg_wdata = 8'h00;
      divisor = 16'h1234;
      {port_xcvr_select, port_tx_busy, port_rts_bit, port_rts_in} = 8'h00;
      port_tx_in = 2'h2;
      irq_level = 11'h000;
      repeat (4) @(negedge clock);
      nrst = 1'b1;
      for (int k = 0; k < 4; k++) rd(adr[k], rst_val[k], "reset_value");
      chk("rts_oe", 20'h3, {18'h0, port_rts_oe});
      for (int k = 0; k < 4; k++) wr(adr[k], 8'hFF);
      for (int k = 0; k < 4; k++) rd(adr[k], wr_val[k], "write_mask");
      chk("wide_only", 20'h1, {19'h0, isa_wide_only_sel});
      // software selects fast mode before any high baud rate
      chk("fast_div", 20'h01234, baud_divisor);
      wr(lipc_pkg::ADDR_MODE_TWO, 8'h00);
      chk("legacy_div", 20'h12340, baud_divisor);
      wr(lipc_pkg::ADDR_GATE_LOW, 8'hA5);
      wr(lipc_pkg::ADDR_GATE_HIGH, 8'h05);
      chk("wide_only", 20'h0, {19'h0, isa_wide_only_sel});
      for (int i = 0; i < 11; i++) begin
         irq_level = 11'h001 << i;
         @(negedge clock);
         chk("serirq", {9'h0, 11'h5A5 & (11'h001 << i)}, {9'h0, serirq_req});
      end
      irq_level = 11'h000;
      @(negedge clock);
      chk("serirq_idle", 20'h0, {9'h0, serirq_req});
      port_xcvr_select = 2'h3;
      port_tx_busy = 2'h1;
      port_rts_in = 2'h1;
      wr(lipc_pkg::ADDR_MODE_ONE, 8'h33);
      chk("auto_oe", 20'h1, {18'h0, port_tx_oe});
      chk("tx_out", 20'h2, {18'h0, port_tx_out});
      chk("rts_out", 20'h1, {18'h0, port_rts_out});
      chk("line", 20'h0, {19'h0, line[0]});
      port_tx_busy = 2'h2;
      @(negedge clock);
      chk("auto_oe", 20'h2, {18'h0, port_tx_oe});
      port_rts_bit = 2'h1;
      wr(lipc_pkg::ADDR_MODE_ONE, 8'h03);
      chk("manual_oe", 20'h2, {18'h0, port_tx_oe});
      port_xcvr_select = 2'h0;
      @(negedge clock);
      chk("rs232_oe", 20'h3, {18'h0, port_tx_oe});
      io(1'b1, 1'b1, 2'h3, 1'b0);
      rd(lipc_pkg::ADDR_GATE_HIGH, 8'h05, "flag_clear");
      wr(lipc_pkg::ADDR_MODE_ONE, 8'h02);
      chk("tx_oe_off", 20'h2, {18'h0, port_tx_oe});
      chk("rts_oe_off", 20'h2, {18'h0, port_rts_oe});
      chk("line_idle", 20'h1, {19'h0, line[0]});
      io(1'b1, 1'b0, 2'h0, 1'b1);
      io(1'b0, 1'b1, 2'h2, 1'b0);
      rd(lipc_pkg::ADDR_GATE_HIGH, 8'h85, "flag_set");
      rd(lipc_pkg::ADDR_GATE_HIGH, 8'h05, "flag_clear");
      isa_cycle = 1'b1;
      rd(lipc_pkg::ADDR_GATE_HIGH, 8'h05, "flag_same");
      rd(lipc_pkg::ADDR_GATE_HIGH, 8'h85, "flag_kept");
      // platform reset in mid run restores the defaults
      nrst = 1'b0;
      repeat (2) @(negedge clock);
      nrst = 1'b1;
      rd(lipc_pkg::ADDR_MODE_ONE, lipc_pkg::MODE1_RESET, "mid_reset");
      rd(lipc_pkg::ADDR_GATE_HIGH, lipc_pkg::GATE_HIGH_RESET, "mid_reset");
      end_of_test();
   end
endmodule
`default_nettype wire
